// ### sbt_pkg.sv
/*
 * Package for the bus clock/timing configuration block: register indices,
 * field positions, reset values, phase lengths and the master state type.
 * Assumes an Avalon-MM slave with 32-bit data, one register per word.
 */
// Operation
// - SCL high phase about twice the low
// - No phase shorter than one overflow period
// - Wait out SCL held low by others
// - Setup before SCL rise, hold after fall
// - Extension: setup 11, hold 12 clocks
// - No extension: hold 3, setup low minus 4
// - SCL high forces timer 2 reload
// - Free after both high over 10 periods
// - Free timeout acts as received STOP
// - Select bits choose overflow clock source
// - Enable bit gates all bus activity
// - Inhibit drops slave events, keeps monitoring
// - Pending START issued after free timeout
package sbt_pkg;
    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_CFG      = 8'hc1;
    localparam logic [7:0] IDX_CTRL     = 8'hc2;
    localparam logic [7:0] IDX_DATA     = 8'hc3;
    localparam logic [7:0] IDX_ISTAT    = 8'hc4;
    localparam logic [7:0] IDX_IMASK    = 8'hc5;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    // ---------------------------------------------------------------
    // Configuration fields
    // ---------------------------------------------------------------
    localparam int CFG_EN   = 7;
    localparam int CFG_INH  = 6;
    localparam int CFG_BUSY = 5;
    localparam int CFG_EXT  = 4;
    localparam int CFG_TOE  = 3;
    localparam int CFG_FTE  = 2;
    // Control fields
    localparam int CTL_MASTER = 7;
    localparam int CTL_START  = 5;
    localparam int CTL_STOP   = 4;
    localparam int CTL_ACKRX  = 2;
    localparam int CTL_IFLAG  = 0;
    // Event status bits
    localparam int EV_BYTE  = 0;
    localparam int EV_STOP  = 1;
    localparam int EV_START = 2;
    // ---------------------------------------------------------------
    // Timing counts
    // ---------------------------------------------------------------
    localparam logic [1:0] LOW_TICKS   = 2'h1;  // Overflow periods of SCL low
    localparam logic [1:0] HIGH_TICKS  = 2'h2;  // Overflow periods of SCL high
    localparam logic [3:0] FREE_TICKS  = 4'ha;  // Periods that must be exceeded
    localparam logic [3:0] HOLD_EXT    = 4'hc;  // Hold clocks, extended
    localparam logic [3:0] HOLD_NORM   = 4'h3;  // Hold clocks, normal
    localparam logic [3:0] SETUP_EXT   = 4'hb;  // Setup clocks, extended
    localparam logic [3:0] SETUP_NORM  = 4'h1;  // Setup clocks after SDA change, normal
    // Master sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_STALL, ST_LOW, ST_HIGH,
        ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_WAIT
    } sbt_state_t;
endpackage : sbt_pkg

// ### sbt_sync.sv
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes inputs asynchronous to ref_clk_i; first stage feeds only the second.
 */
`timescale 1ns/10ps
module sbt_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;  // First stage, read only by the second

    // Per-bit double flop
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                meta[g]   <= 1'b1;
                sync_o[g] <= 1'b1;
            end else begin
                meta[g]   <= async_i[g];
                sync_o[g] <= meta[g];
            end
        end
    end
endmodule : sbt_sync

// ### sbt_bus_monitor.sv
/*
 * Bus monitor: START/STOP detection, busy state and free timeout.
 * Assumes synchronised SCL/SDA and a one-cycle source tick.
 */
`timescale 1ns/10ps
module sbt_bus_monitor
    import sbt_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Bus levels and configuration
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic enable_i,
    input  wire logic fte_i,
    input  wire logic tick_i,
    // Events
    output logic      start_det_o,
    output logic      stop_det_o,
    output logic      free_o,
    output logic      busy_o
);
    logic       scl_q;     // Previous SCL
    logic       sda_q;     // Previous SDA
    logic [3:0] free_cnt;  // Periods with both lines high

    // Edge history
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign start_det_o = enable_i & scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det_o  = enable_i & scl_i & scl_q & ~sda_q & sda_i;
    assign free_o = enable_i & fte_i & tick_i & (free_cnt == FREE_TICKS);

    // Free timeout counter, fires once when count passes the limit
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !(scl_i && sda_i && enable_i && fte_i)) begin
            free_cnt <= 4'h0;
        end else if (tick_i && free_cnt <= FREE_TICKS) begin
            free_cnt <= free_cnt + 4'h1;
        end
    end

    // Busy: set by START, cleared by STOP or free timeout
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !enable_i) begin
            busy_o <= 1'b0;
        end else if (start_det_o) begin
            busy_o <= 1'b1;
        end else if (stop_det_o || free_o) begin
            busy_o <= 1'b0;
        end
    end
endmodule : sbt_bus_monitor

// ### sbt_smbus_timing.sv
/*
 * Bus clock/timing configuration block with a byte-wise master sequencer.
 * Holds the configuration register, SCL generation, SDA setup/hold,
 * timer 2 reload forcing, free timeout and an event interrupt.
 * Assumes timer overflow pulses come from logic on ref_clk_i and that
 * the open-drain pins are resolved outside (output enable pulls low).
 */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module sbt_smbus_timing
    import sbt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Timer overflow sources and timer 2 control
    input  wire logic        t0_ovf_i,
    input  wire logic        t1_ovf_i,
    input  wire logic        t2_hi_ovf_i,
    input  wire logic        t2_lo_ovf_i,
    input  wire logic        timer2_split_mode_i,
    output logic             t2_reload_hi_o,
    output logic             t2_reload_lo_o,
    // Open-drain bus pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Interrupt
    output logic             irq_o
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [7:0]  bus_clock_config;  // Writable configuration bits
    logic        start_request;     // Pending master START
    logic        stop_flag;         // STOP request or STOP seen
    logic        iflag;             // Interface interrupt flag, stalls SCL
    logic        ack_rx;            // Last acknowledge sampled
    logic        master;            // Sequencer owns the bus
    logic [7:0]  shift_data_register;  // Outgoing byte
    logic [2:0]  istat;             // Sticky events
    logic [2:0]  imask;             // Event mask
    logic [2:0]  rd_snap;           // Status bits returned by the last read
    logic        served;            // Second cycle of a bus access
    sbt_state_t  state;             // Master sequencer state
    logic [3:0]  bit_cnt;           // Bit within the byte, 8 is acknowledge
    logic [1:0]  ticks;             // Overflow periods in this phase
    logic [3:0]  hold_cnt;          // Clocks since SCL fell
    logic [3:0]  setup_cnt;         // Clocks since SDA last changed
    logic        scl_drive_low;     // Pull SCL low
    logic        sda_drive_low;     // Pull SDA low
    logic [1:0]  sync_lv;           // Synchronised {scl, sda}
    logic        scl_s;
    logic        sda_s;
    logic        tick;              // Selected overflow pulse
    logic        en;
    logic        ext;
    logic        start_det;
    logic        stop_det;
    logic        free_evt;
    logic        busy;
    logic        acc;               // Access completes this edge
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  widx;
    logic [7:0]  wbyte;
    logic        next_sda_low;      // Level for the bit to be sent
    logic        hold_ok;
    logic        setup_ok;
    logic [2:0]  events;

    // Clock source decode
    function automatic logic src_tick(input logic [1:0] sel, input logic a, input logic b,
                                      input logic c, input logic d);
        case (sel)
            2'h0:    src_tick = a;
            2'h1:    src_tick = b;
            2'h2:    src_tick = c;
            default: src_tick = d;
        endcase
    endfunction : src_tick

    // Register index from byte address, invalid if not aligned
    function automatic logic [7:0] reg_index(input logic [9:0] adr);
        reg_index = (adr[1:0] == 2'h0) ? adr[9:2] : 8'hff;
    endfunction : reg_index

    // ---------------------------------------------------------------
    // Pin synchronisers and bus monitor
    // ---------------------------------------------------------------
    sbt_sync #(.W(2)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({scl_i, sda_i}),
        .sync_o    (sync_lv)
    );
    assign scl_s = sync_lv[1];
    assign sda_s = sync_lv[0];
    assign en    = bus_clock_config[CFG_EN];
    assign ext   = bus_clock_config[CFG_EXT];
    assign tick  = src_tick(bus_clock_config[1:0], t0_ovf_i, t1_ovf_i,
                            t2_hi_ovf_i, t2_lo_ovf_i);

    sbt_bus_monitor u_mon (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .scl_i       (scl_s),
        .sda_i       (sda_s),
        .enable_i    (en),
        .fte_i       (bus_clock_config[CFG_FTE]),
        .tick_i      (tick),
        .start_det_o (start_det),
        .stop_det_o  (stop_det),
        .free_o      (free_evt),
        .busy_o      (busy)
    );

    // ---------------------------------------------------------------
    // Timer 2 reload forcing
    // ---------------------------------------------------------------
    assign t2_reload_hi_o = en & bus_clock_config[CFG_TOE] & scl_s;
    assign t2_reload_lo_o = t2_reload_hi_o & ~timer2_split_mode_i;

    // ---------------------------------------------------------------
    // Avalon-MM access: one wait cycle, then completion
    // ---------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~served;
    assign acc    = (avs_read_i | avs_write_i) & served;
    assign wr_acc = acc & avs_write_i & avs_byteenable_i[0];
    assign rd_acc = acc & avs_read_i;
    assign widx   = reg_index(avs_address_i);
    assign wbyte  = avs_writedata_i[7:0];

    // Wait-state tracker
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            served <= 1'b0;
        end else begin
            served <= (avs_read_i | avs_write_i) & ~served;
        end
    end

    // Read data, captured in the wait cycle and held through completion
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0;
            rd_snap        <= 3'h0;
        end else if (avs_read_i && !served) begin
            rd_snap <= 3'h0;
            case (widx)
                IDX_CFG:   avs_readdata_o <= {24'h0, bus_clock_config[7:6], busy, bus_clock_config[4:0]};
                IDX_CTRL:  avs_readdata_o <= {24'h0, master, 1'b0, start_request, stop_flag,
                                              1'b0, ack_rx, 1'b0, iflag};
                IDX_DATA:  avs_readdata_o <= {24'h0, shift_data_register};
                IDX_ISTAT: begin
                    avs_readdata_o <= {29'h0, istat};
                    rd_snap        <= istat;
                end
                IDX_IMASK: avs_readdata_o <= {29'h0, imask};
                default:   avs_readdata_o <= 32'h0;  // Unmapped reads zero
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Configuration and data registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_clock_config <= CFG_RESET;
            imask            <= 3'h0;
        end else if (wr_acc) begin
            if (widx == IDX_CFG) begin
                bus_clock_config <= wbyte & ~(8'h1 << CFG_BUSY);
            end
            if (widx == IDX_IMASK) begin
                imask <= wbyte[2:0];
            end
        end
    end

    // Outgoing byte
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            shift_data_register <= 8'h00;
        end else if (wr_acc && widx == IDX_DATA) begin
            shift_data_register <= wbyte;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status: set wins over read-clear
    // ---------------------------------------------------------------
    assign events[EV_BYTE]  = (state == ST_HIGH) && ticks >= HIGH_TICKS && tick && scl_s && bit_cnt == 4'h8;
    assign events[EV_STOP]  = free_evt | (stop_det & ~master & ~bus_clock_config[CFG_INH]);
    assign events[EV_START] = (state == ST_START) && ticks >= HIGH_TICKS && tick;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            istat <= 3'h0;
        end else begin
            istat <= (istat & ~(rd_acc ? rd_snap : 3'h0)) | events;
        end
    end
    assign irq_o = |(istat & imask);

    // ---------------------------------------------------------------
    // Control flags
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !en) begin
            start_request <= 1'b0;
            stop_flag     <= 1'b0;
            iflag         <= 1'b0;
        end else begin
            if (wr_acc && widx == IDX_CTRL) begin
                start_request <= wbyte[CTL_START];
                stop_flag     <= wbyte[CTL_STOP];
                iflag         <= wbyte[CTL_IFLAG];
            end
            if (state == ST_STOP_WAIT) begin
                stop_flag <= 1'b0;  // Master STOP sent
            end
            if (events[EV_STOP]) begin
                stop_flag <= 1'b1;
            end
            if (|events) begin
                iflag <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Setup and hold counters
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !scl_drive_low) begin
            hold_cnt <= 4'h0;
        end else if (hold_cnt != 4'hf) begin
            hold_cnt <= hold_cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || (next_sda_low != sda_drive_low)) begin
            setup_cnt <= 4'h0;
        end else if (setup_cnt != 4'hf) begin
            setup_cnt <= setup_cnt + 4'h1;
        end
    end

    assign hold_ok  = hold_cnt >= (ext ? HOLD_EXT : HOLD_NORM);
    assign setup_ok = setup_cnt >= (ext ? SETUP_EXT : SETUP_NORM);

    // Level for SDA in the current phase
    always_comb begin
        next_sda_low = sda_drive_low;
        if ((state == ST_LOW || state == ST_STALL) && hold_ok) begin
            next_sda_low = (bit_cnt == 4'h8) ? 1'b0 : ~shift_data_register[3'h7 - bit_cnt[2:0]];
        end else if (state == ST_STOP_LOW && hold_ok) begin
            next_sda_low = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Master sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !en) begin
            state         <= ST_IDLE;
            scl_drive_low <= 1'b0;
            sda_drive_low <= 1'b0;
            bit_cnt       <= 4'h0;
            ticks         <= 2'h0;
            master        <= 1'b0;
            ack_rx        <= 1'b0;
        end else begin
            if (tick && ticks != 2'h3) begin
                ticks <= ticks + 2'h1;
            end
            case (state)
                // Wait for a free bus with START pending
                ST_IDLE: begin
                    if (start_request && (!busy || free_evt)) begin
                        sda_drive_low <= 1'b1;
                        master        <= 1'b1;
                        ticks         <= 2'h0;
                        state         <= ST_START;
                    end
                end
                // START hold with SCL high
                ST_START: begin
                    if (ticks >= HIGH_TICKS && tick) begin
                        scl_drive_low <= 1'b1;
                        bit_cnt       <= 4'h0;
                        state         <= ST_STALL;
                    end
                end
                // SCL held low until software clears the flag
                ST_STALL: begin
                    sda_drive_low <= next_sda_low;
                    ticks         <= 2'h0;
                    if (!iflag) begin
                        state <= stop_flag ? ST_STOP_LOW : ST_LOW;
                    end
                end
                // Low phase: SDA after hold, release after period and setup
                ST_LOW: begin
                    sda_drive_low <= next_sda_low;
                    if (ticks >= LOW_TICKS && setup_ok && hold_ok && next_sda_low == sda_drive_low) begin
                        scl_drive_low <= 1'b0;
                        ticks         <= 2'h0;
                        state         <= ST_HIGH;
                    end
                end
                // High phase counts only once SCL is really high
                ST_HIGH: begin
                    if (!scl_s) begin
                        ticks <= 2'h0;
                    end else if (ticks >= HIGH_TICKS && tick) begin
                        scl_drive_low <= 1'b1;
                        ticks         <= 2'h0;
                        if (bit_cnt == 4'h8) begin
                            ack_rx <= ~sda_s;
                            state  <= ST_STALL;
                            bit_cnt <= 4'h0;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            state   <= ST_LOW;
                        end
                    end
                end
                // STOP: SDA low with SCL low
                ST_STOP_LOW: begin
                    sda_drive_low <= next_sda_low;
                    if (ticks >= LOW_TICKS && setup_ok && hold_ok && sda_drive_low) begin
                        scl_drive_low <= 1'b0;
                        ticks         <= 2'h0;
                        state         <= ST_STOP_HIGH;
                    end
                end
                // STOP: release SDA after the high time
                ST_STOP_HIGH: begin
                    if (!scl_s) begin
                        ticks <= 2'h0;
                    end else if (ticks >= HIGH_TICKS && tick) begin
                        sda_drive_low <= 1'b0;
                        state         <= ST_STOP_WAIT;
                    end
                end
                // Own STOP seen on the bus
                ST_STOP_WAIT: begin
                    if (!busy) begin
                        master <= 1'b0;
                        state  <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = scl_drive_low;
    assign sda_oe_o = sda_drive_low;
endmodule : sbt_smbus_timing

// ### sbt_smbus_timing_properties.sv
/* Port checker for sbt_smbus_timing.
   Assumes a bind from the bench top; one clock domain. */
`timescale 1ns/10ps
module sbt_smbus_timing_properties (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        timer2_split_mode_i,
    input wire logic        t2_reload_hi_o,
    input wire logic        t2_reload_lo_o,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe_o,
    input wire logic        sda_o,
    input wire logic        sda_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire req = avs_read_i | avs_write_i;  // Any bus request
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o) else $error("no wait cycle");
    answer_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
    reload_pair_a: assert property (t2_reload_lo_o |-> t2_reload_hi_o && !timer2_split_mode_i) else $error("lo reload");
    reload_low_a: assert property (!scl_i [*3] |-> !t2_reload_hi_o) else $error("reload with clock low");
    hold_min_a: assert property ($rose(scl_oe_o) |-> $stable(sda_oe_o) [*3]) else $error("data hold short");
    setup_min_a: assert property ($fell(scl_oe_o) |-> $stable(sda_oe_o)) else $error("data setup short");
    pins_low_a: assert property (!scl_o && !sda_o) else $error("pin data not low");
    rdata_hi_a: assert property (avs_readdata_o[31:8] == 24'h0) else $error("read data high bits set");
    rd_c: cover property (avs_read_i && !avs_waitrequest_o);
    split_c: cover property (t2_reload_hi_o && timer2_split_mode_i);
    rise_c: cover property ($fell(scl_oe_o));
endmodule : sbt_smbus_timing_properties

// ### sbt_bus_partner.sv
/* Far-side bus device: acknowledges the first byte after each START, may stretch clock low.
   Assumes resolved open-drain levels with pull-ups. */
`timescale 1ns/10ps
module sbt_bus_partner (
    input  wire logic ref_clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic stretch_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    logic       scl_q = 0, sda_q = 0;  // Previous levels
    logic [3:0] falls = 0;             // Clock falls since START
    logic [4:0] hold_cnt = 0;          // Stretch cycles left
    initial {scl_oe_o, sda_oe_o} = 2'h0;
    always @(posedge ref_clk_i) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (scl_i && sda_q && !sda_i) falls <= 4'h0;
        else if (scl_q && !scl_i) falls <= falls + 4'h1;
        sda_oe_o <= (falls == 4'h9);  // Acknowledge slot
        if (scl_q && !scl_i && stretch_i) hold_cnt <= 5'h1f;
        else if (hold_cnt != 5'h0) hold_cnt <= hold_cnt - 5'h1;
        scl_oe_o <= (hold_cnt != 5'h0);
    end
endmodule : sbt_bus_partner

// ### sbt_smbus_timing_tb_top.sv
/* Bench: registers, reload forcing, free timeout, interrupt, byte transfers.
   Assumes the partner model and the bound checker. */
`timescale 1ns/10ps
module sbt_smbus_timing_tb_top;
    import sbt_pkg::*;
    logic ref_clk_i = 0, rst_i = 1, rd = 0, wr = 0, split = 0, stretch = 0;
    logic [9:0] addr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [2:0] cnt = 0;
    logic [8:0] sh = 0;
    logic wt, irq, rl_hi, rl_lo, scl_oe, sda_oe, p_scl_oe, p_sda_oe;
    int fails = 0, samples_checked = 0;
    wire scl = !(scl_oe | p_scl_oe);
    wire sda = !(sda_oe | p_sda_oe);
    wire ovf = (cnt == 3'h7);  // One tick per 320 ns
    always @(posedge ref_clk_i) cnt <= cnt + 3'h1;
    always @(posedge scl) sh <= {sh[7:0], sda};
    sbt_smbus_timing u_dut (.ref_clk_i, .rst_i, .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .t0_ovf_i(ovf), .t1_ovf_i(ovf), .t2_hi_ovf_i(ovf), .t2_lo_ovf_i(ovf), .timer2_split_mode_i(split),
        .t2_reload_hi_o(rl_hi), .t2_reload_lo_o(rl_lo), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq));
    sbt_bus_partner u_peer (.ref_clk_i, .scl_i(scl), .sda_i(sda), .stretch_i(stretch),
        .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe));
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        rd <= !w; wr <= w; addr <= {idx, 2'b00}; wdata <= {24'h0, d};
        do begin @(posedge ref_clk_i); n++; end while (wt !== 1'b0 && n < 50);
        if (wt !== 1'b0) begin fails++; close_out(); end
        got = rdata;
        rd <= 0; wr <= 0;
        #1;
    endtask : acc
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 3000) begin @(posedge ref_clk_i); #1; n++; end
        if (n == 3000) begin fails++; close_out(); end
    endtask : wait_irq
    task automatic t_regs();
        acc(0, IDX_CFG, 0); chk("cfg reset", got, {24'h0, CFG_RESET});
        for (int s = 0; s < 4; s++) begin
            acc(1, IDX_CFG, 8'h80 | s[7:0]); acc(0, IDX_CFG, 0); chk("cfg source", got, 32'h80 | s);
        end
        acc(1, 8'h10, 8'hff); acc(0, 8'h10, 0); chk("unmapped", got, 32'h0);
    endtask : t_regs
    task automatic t_reload();
        acc(1, IDX_CFG, 8'h88); chk("reload both", {rl_hi, rl_lo}, 2'b11);
        split <= 1; @(posedge ref_clk_i); #1; chk("reload split", {rl_hi, rl_lo}, 2'b10);
        split <= 0;
    endtask : t_reload
    task automatic t_free();
        acc(1, IDX_IMASK, 0); acc(1, IDX_CFG, 8'h84);
        repeat (150) @(posedge ref_clk_i); #1; chk("irq masked", irq, 1'b0);
        acc(1, IDX_IMASK, 8'h02); chk("irq free", irq, 1'b1);
        acc(0, IDX_ISTAT, 0); chk("free status", got, 32'h2);
        chk("irq cleared", irq, 1'b0);
        acc(1, IDX_CFG, 0);
    endtask : t_free
    task automatic t_xfer(input logic ext, input logic str);
        int n = 0;
        stretch <= str; acc(1, IDX_CFG, {3'b100, ext, 4'h8}); acc(1, IDX_IMASK, 8'h05);
        acc(1, IDX_CTRL, 8'h20); wait_irq(); acc(0, IDX_ISTAT, 0); chk("start status", got, 32'h4);
        acc(0, IDX_CFG, 0); chk("busy set", got[CFG_BUSY], 1'b1);
        acc(1, IDX_DATA, 8'ha5); acc(1, IDX_CTRL, 8'h00); wait_irq();
        acc(0, IDX_ISTAT, 0); chk("byte status", got, 32'h1);
        chk("wire byte", sh, 9'h14a);
        acc(1, IDX_CTRL, 8'h10);
        do begin acc(0, IDX_CFG, 0); n++; end while (got[CFG_BUSY] !== 1'b0 && n < 200);
        chk("busy clear", got[CFG_BUSY], 1'b0);
        acc(0, IDX_CTRL, 0); chk("ctrl end", got, 32'h4);
    endtask : t_xfer
    initial forever #20 ref_clk_i = ~ref_clk_i;
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 0;
        t_regs(); t_reload(); t_free(); t_xfer(1, 0); t_xfer(0, 1);
        close_out();
    end
endmodule : sbt_smbus_timing_tb_top
bind sbt_smbus_timing sbt_smbus_timing_properties u_props (.ref_clk_i, .rst_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .timer2_split_mode_i, .t2_reload_hi_o, .t2_reload_lo_o, .scl_i,
    .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
